// ===== count_gating_control.sv
`timescale 1ns/10ps
// Overview of operation
// - rising active start pulse begins counting.
// - counting runs from start until stop; stop ends counting.
// - software start command acts like a start pulse.
// - software stop command acts like a stop pulse.
// - gate low suspends counting in normal mode; high resumes.
// - unconnected gate reads high via pull-up.
// - counting indicator off while gate low, on while high and started.
// - gate-sync mode stores one record on each gate-off edge while started, until memory is full.
// - memory holds 56000 records (8 ch) or 8000 (64 ch).
// - gate-edge mode keeps counting while gate is low.
// - run output high when started and gate high, and while stretched.
// - run output can gate another unit's counting.
// - run pulse can be stretched to at least 10 us.
// - start ignored once limit reached in counter or timer stop mode.
// - start, stop, gate and run each may be inverted.
module count_gating_control import count_gating_pkg::*; #(
   parameter bit WIDE_BUILD = 1'b0      // 1: sixty-four-channel build
) (
   input  wire logic      ref_clk,
   input  wire logic      rst_b,
   input  wire logic      start_pin,
   input  wire logic      stop_pin,
   input  wire logic      gate_pin,
   input  wire logic      start_inv,
   input  wire logic      stop_inv,
   input  wire logic      gate_inv,
   input  wire logic      run_inv,
   input  wire logic      sw_start,
   input  wire logic      sw_stop,
   input  wire acq_mode_t acq_mode,
   input  wire logic      limit_stop_en,
   input  wire logic      limit_hit,
   input  wire logic      stretch_en,
   input  wire logic      mem_clear,
   output logic           count_enable,
   output logic           count_led,
   output logic           run_pin,
   output logic           snap_req,
   output logic [REC_ADDR_W-1:0] snap_addr,
   output logic           mem_full
);

   // ---------------------------------------------------------------
   // input conditioning
   // ---------------------------------------------------------------
   logic start_lvl;
   logic start_rise;
   logic stop_lvl;
   logic stop_rise;
   logic gate_lvl;
   logic gate_rise;
   logic gate_fall_q;
   logic gate_prev_q;
   logic gate_on;

   // polarity applied ahead of the synchroniser so edges follow it
   pin_sync u_start (
      .ref_clk   (ref_clk),
      .rst_b     (rst_b),
      .reset_val (1'b0),
      .pin_in    (start_pin ^ start_inv),
      .level_q   (start_lvl),
      .rise_q    (start_rise)
   );

   pin_sync u_stop (
      .ref_clk   (ref_clk),
      .rst_b     (rst_b),
      .reset_val (1'b0),
      .pin_in    (stop_pin ^ stop_inv),
      .level_q   (stop_lvl),
      .rise_q    (stop_rise)
   );

   // pad pull-up makes an open gate pin read high; the chain is
   // inverted, so its idle gate-on level resets as 0
   pin_sync u_gate (
      .ref_clk   (ref_clk),
      .rst_b     (rst_b),
      .reset_val (1'b0),
      .pin_in    (~(gate_pin ^ gate_inv)),
      .level_q   (gate_lvl),
      .rise_q    (gate_rise)
   );

   // inverted chain resets low, so an open gate counts as on
   assign gate_on = ~gate_lvl;

   // gate-off edge detect on the filtered level
   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         gate_prev_q <= 1'b1;
         gate_fall_q <= 1'b0;
      end else begin
         gate_prev_q <= gate_on;
         gate_fall_q <= gate_prev_q & ~gate_on;
      end
   end

   // ---------------------------------------------------------------
   // run state
   // ---------------------------------------------------------------
   run_state_t state_q;
   logic       go_req;
   logic       end_req;

   assign go_req  = start_rise | sw_start;
   assign end_req = stop_rise | sw_stop;

   // stop beats start; limit blocks a fresh start
   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         state_q <= ST_IDLE;
      end else begin
         case (state_q)
            ST_IDLE: begin
               if (go_req && !end_req &&
                   !(limit_stop_en && limit_hit)) begin
                  state_q <= ST_RUN;
               end
            end
            ST_RUN: begin
               if (end_req) begin
                  state_q <= ST_IDLE;
               end else if (limit_stop_en && limit_hit &&
                            acq_mode == ACQ_NORMAL) begin
                  state_q <= ST_IDLE;
               end
            end
            default: state_q <= ST_IDLE;
         endcase
      end
   end

   // ---------------------------------------------------------------
   // count enable and indicators
   // ---------------------------------------------------------------
   logic running;
   logic active;

   assign running = (state_q == ST_RUN);
   assign active  = running & gate_on;

   // edge mode ignores gate for counting only
   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         count_enable <= 1'b0;
         count_led    <= 1'b0;
      end else begin
         count_enable <= (acq_mode == ACQ_GATE_EDGE) ?
                         running : active;
         count_led    <= active;
      end
   end

   // ---------------------------------------------------------------
   // run output stretcher
   // ---------------------------------------------------------------
   logic [STRETCH_W-1:0] stretch_q;
   logic                 run_raw;

   // holds run for a minimum width so short runs can trigger
   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         stretch_q <= '0;
      end else if (active && stretch_en) begin
         stretch_q <= STRETCH_W'(RUN_STRETCH_CYC - 1);
      end else if (stretch_q != '0) begin
         stretch_q <= stretch_q - 1'b1;
      end
   end

   assign run_raw = active | (stretch_en && stretch_q != '0);

   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         run_pin <= 1'b0 ^ run_inv;
      end else begin
         run_pin <= run_raw ^ run_inv;
      end
   end

   // ---------------------------------------------------------------
   // gate-synchronous snapshot addressing
   // ---------------------------------------------------------------
   logic [REC_ADDR_W-1:0] depth;

   // depth of record memory depends on channel build
   assign depth = WIDE_BUILD ? REC_ADDR_W'(DEPTH_64CH)
                             : REC_ADDR_W'(DEPTH_8CH);

   logic last_slot;

   assign last_slot = (snap_addr == depth - 1'b1);

   // one record per gate-off edge, none once full; the index moves
   // the cycle after the strobe so the store sees the slot it names
   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         snap_req  <= 1'b0;
         snap_addr <= '0;
         mem_full  <= 1'b0;
      end else begin
         snap_req <= gate_fall_q && running && !mem_clear &&
                     acq_mode == ACQ_GATE_SYNC && !mem_full;
         if (mem_clear) begin
            snap_addr <= '0;
         end else if (snap_req && !last_slot) begin
            snap_addr <= snap_addr + 1'b1;
         end
         // a store into the last slot wins over a clear in one cycle
         if (snap_req && last_slot) begin
            mem_full <= 1'b1;
         end else if (mem_clear) begin
            mem_full <= 1'b0;
         end
      end
   end

   // start and stop use only their edges; gate uses only its level, not its edge
   logic unused_lvls;
   assign unused_lvls = start_lvl ^ stop_lvl ^ gate_rise;

endmodule // count_gating_control

// ===== count_gating_control_tb.sv
`timescale 1ns/10ps
module count_gating_control_tb;
   import count_gating_pkg::*;
   logic ref_clk, rst_b, sw_start, sw_stop, mem_clear;
   logic limit_stop_en, limit_hit, stretch_en;
   logic start_inv, stop_inv, gate_inv, run_inv;
   acq_mode_t acq_mode;
   wire start_pin, stop_pin, gate_pin, count_enable, count_led;
   wire run_pin, snap_req, mem_full;
   wire [REC_ADDR_W-1:0] snap_addr;
   int errors, checks, cycles;
   logic [15:0] q[$];
   // -------------------------------------------
   // clock, parts and helpers
   // -------------------------------------------
   initial begin
      ref_clk = 1'h0;
      forever #50 ref_clk = ~ref_clk;
   end
   trig_src trig (.ref_clk, .start_pin, .stop_pin, .gate_pin);
   // straps flip the level that the trigger source shows at the pins
   count_gating_control uut (.ref_clk, .rst_b,
      .start_pin(start_pin ^ start_inv), .stop_pin(stop_pin ^ stop_inv),
      .gate_pin(gate_pin ^ gate_inv), .start_inv, .stop_inv, .gate_inv,
      .run_inv, .sw_start, .sw_stop, .acq_mode, .limit_stop_en,
      .limit_hit, .stretch_en, .mem_clear, .count_enable, .count_led,
      .run_pin, .snap_req, .snap_addr, .mem_full);
   task automatic wrap_up;
      if (errors == 0 && checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   task automatic chk(input logic [15:0] s, input logic [15:0] e);
      checks++;
      if (s !== e) begin
         errors++;
         $display("FAIL %0t saw %h want %h", $time, s, e);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(negedge ref_clk);
   endtask
   task automatic sw(input logic a, input logic b);
      sw_start = a;
      sw_stop = b;
      cyc(1);
      sw_start = 1'h0;
      sw_stop = 1'h0;
   endtask
   // a hang is cut off well past the expected run length
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 3000) begin
         errors++;
         wrap_up;
      end
   end
   // each stored record must match the oldest noted address
   always @(negedge ref_clk) if (rst_b && snap_req === 1'h1) begin
      if (q.size() == 0) chk(1'h1, 1'h0);
      else chk(snap_addr, q.pop_front());
   end
   // -------------------------------------------
   // scenarios
   // -------------------------------------------
   initial begin
      void'($urandom(19759));
      {rst_b, sw_start, sw_stop, mem_clear} = 4'h0;
      {limit_stop_en, limit_hit, stretch_en} = 3'h0;
      {start_inv, stop_inv, gate_inv, run_inv} = 4'h0;
      acq_mode = ACQ_NORMAL;
      cyc(10);
      chk(run_pin, 1'h0);
      rst_b = 1'h1;
      cyc(2);
      sw(1'h1, 1'h0);
      cyc(3);
      chk(count_enable, 1'h1);
      chk(run_pin, 1'h1);
      trig.gate(1'h0);
      cyc(8);
      chk(count_led, 1'h0);
      chk(count_enable, 1'h0);
      trig.gate(1'h1);
      cyc(8);
      chk(count_enable, 1'h1);
      sw(1'h0, 1'h1);
      cyc(3);
      chk(count_enable, 1'h0);
      trig.pulse(3, 1'b0);
      cyc(6);
      chk(count_enable, 1'h1);
      trig.pulse(3, 1'b1);
      cyc(6);
      chk(count_enable, 1'h0);
      sw(1'h1, 1'h1);
      cyc(3);
      chk(count_enable, 1'h0);
      {limit_stop_en, limit_hit} = 2'h3;
      sw(1'h1, 1'h0);
      cyc(3);
      chk(count_enable, 1'h0);
      {limit_stop_en, limit_hit} = 2'h0;
      acq_mode = ACQ_GATE_SYNC;
      sw(1'h1, 1'h0);
      cyc(3);
      for (int i = 0; i < 6; i++) begin
         q.push_back(16'(i));
         trig.gate(1'h0);
         cyc(4 + $urandom % 8);
         trig.gate(1'h1);
         cyc(4 + $urandom % 8);
      end
      cyc(10);
      chk(16'(q.size()), 16'h0);
      chk(mem_full, 1'h0);
      sw(1'h0, 1'h1);
      mem_clear = 1'h1;
      cyc(1);
      mem_clear = 1'h0;
      cyc(1);
      chk(snap_addr, 16'h0);
      acq_mode = ACQ_GATE_EDGE;
      sw(1'h1, 1'h0);
      trig.gate(1'h0);
      cyc(8);
      chk(count_enable, 1'h1);
      chk(count_led, 1'h0);
      trig.gate(1'h1);
      sw(1'h0, 1'h1);
      cyc(3);
      acq_mode = ACQ_NORMAL;
      stretch_en = 1'h1;
      sw(1'h1, 1'h0);
      cyc(3);
      sw(1'h0, 1'h1);
      cyc(5);
      chk(run_pin, 1'h1);
      cyc(RUN_STRETCH_CYC + 10);
      chk(run_pin, 1'h0);
      // reset in mid-run, then every strap set to active low
      sw(1'h1, 1'h0);
      cyc(3);
      rst_b = 1'h0;
      {start_inv, stop_inv, gate_inv, run_inv} = 4'hF;
      stretch_en = 1'h0;
      cyc(3);
      chk(count_led, 1'h0);
      chk(run_pin, 1'h1);
      rst_b = 1'h1;
      cyc(2);
      trig.pulse(3, 1'b0);
      cyc(6);
      chk(count_enable, 1'h1);
      chk(run_pin, 1'h0);
      trig.gate(1'h0);
      cyc(8);
      chk(count_enable, 1'h0);
      trig.gate(1'h1);
      cyc(8);
      trig.pulse(3, 1'b1);
      cyc(6);
      chk(count_enable, 1'h0);
      chk(run_pin, 1'h1);
      wrap_up;
   end
endmodule // count_gating_control_tb

// ===== count_gating_monitor.sv
`timescale 1ns/10ps
// -------------------------------------------
// port checker
// -------------------------------------------
module count_gating_monitor import count_gating_pkg::*; (
   input wire logic                  ref_clk,
   input wire logic                  rst_b,
   input wire logic                  gate_pin,
   input wire logic                  gate_inv,
   input wire logic                  run_inv,
   input wire logic                  sw_start,
   input wire logic                  sw_stop,
   input wire acq_mode_t             acq_mode,
   input wire logic                  limit_stop_en,
   input wire logic                  limit_hit,
   input wire logic                  stretch_en,
   input wire logic                  mem_clear,
   input wire logic                  count_enable,
   input wire logic                  count_led,
   input wire logic                  run_pin,
   input wire logic                  snap_req,
   input wire logic [REC_ADDR_W-1:0] snap_addr,
   input wire logic                  mem_full
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_b);
   // gate as seen after the polarity strap
   wire g_on = gate_pin ^ gate_inv;
   sequence s_gate_off; !g_on [*8]; endsequence
   sequence s_sw_go;
      sw_start && !sw_stop && !limit_stop_en && acq_mode == ACQ_GATE_EDGE;
   endsequence
   property p_sw_go; s_sw_go |-> ##[1:3] count_enable; endproperty
   property p_sw_stop; sw_stop |-> ##3 !count_enable; endproperty
   property p_gate_led; s_gate_off |-> !count_led; endproperty
   property p_gate_cnt;
      acq_mode == ACQ_NORMAL throughout s_gate_off |-> !count_enable;
   endproperty
   property p_run; !stretch_en |-> (run_pin ^ run_inv) == count_led;
   endproperty
   property p_limit;
      sw_start && limit_stop_en && limit_hit && !count_enable &&
      acq_mode == ACQ_NORMAL |-> ##3 !count_enable;
   endproperty
   property p_snap;
      snap_req |=> !snap_req && (snap_addr == $past(snap_addr) + 16'h1 ||
                                  mem_full || $past(mem_clear));
   endproperty
   property p_snap_mode;
      snap_req |-> acq_mode == ACQ_GATE_SYNC && !mem_full;
   endproperty
   // short run pulses must stay visible to a trigger input
   property p_stretch;
      stretch_en && $fell(count_led) |-> (run_pin ^ run_inv) [*8];
   endproperty
   a_sw_go:     assert property (p_sw_go) else $error("no start");
   a_sw_stop:   assert property (p_sw_stop) else $error("no stop");
   a_gate_led:  assert property (p_gate_led) else $error("led");
   a_gate_cnt:  assert property (p_gate_cnt) else $error("gate");
   a_run:       assert property (p_run) else $error("run out");
   a_limit:     assert property (p_limit) else $error("limit");
   a_snap:      assert property (p_snap) else $error("snap");
   a_snap_mode: assert property (p_snap_mode) else $error("mode");
   a_stretch:   assert property (p_stretch) else $error("stretch");
endmodule // count_gating_monitor

bind count_gating_control count_gating_monitor mon (.ref_clk, .rst_b,
   .gate_pin, .gate_inv, .run_inv, .sw_start, .sw_stop, .acq_mode,
   .limit_stop_en, .limit_hit, .stretch_en, .mem_clear, .count_enable,
   .count_led,
   .run_pin, .snap_req, .snap_addr, .mem_full);

// ===== count_gating_pkg.sv
package count_gating_pkg;

   // ---------------------------------------------------------------
   // clock and timing
   // ---------------------------------------------------------------
   localparam int unsigned CLK_PERIOD_NS     = 100;
   localparam int unsigned MIN_PULSE_NS      = 100;
   localparam int unsigned RUN_STRETCH_US    = 10;
   // least stretch time, rounded up to whole cycles
   localparam int unsigned RUN_STRETCH_CYC   =
      (RUN_STRETCH_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned STRETCH_W         = 8;

   // ---------------------------------------------------------------
   // acquisition memory depth
   // ---------------------------------------------------------------
   localparam int unsigned DEPTH_8CH         = 56000;
   localparam int unsigned DEPTH_64CH        = 8000;
   localparam int unsigned REC_ADDR_W        = 16;

   // ---------------------------------------------------------------
   // acquisition modes
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {
      ACQ_NORMAL,
      ACQ_GATE_SYNC,
      ACQ_GATE_EDGE
   } acq_mode_t;

   typedef enum logic {
      ST_IDLE,
      ST_RUN
   } run_state_t;

endpackage

// ===== pin_sync.sv
`timescale 1ns/10ps
// ---------------------------------------------------------------
// three-stage synchroniser, change accepted when stages 2 and 3 agree
// ---------------------------------------------------------------
module pin_sync import count_gating_pkg::*; (
   input  wire logic ref_clk,
   input  wire logic rst_b,
   input  wire logic reset_val,
   input  wire logic pin_in,
   output logic      level_q,
   output logic      rise_q
);

   logic s1_q;
   logic s2_q;
   logic s3_q;

   // plain shift chain; only s2 reads s1
   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         s1_q <= reset_val;
         s2_q <= reset_val;
         s3_q <= reset_val;
      end else begin
         s1_q <= pin_in;
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end

   // filtered level and its rising edge
   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         level_q <= reset_val;
         rise_q  <= 1'b0;
      end else begin
         rise_q <= 1'b0;
         if (s2_q == s3_q && s2_q != level_q) begin
            level_q <= s2_q;
            rise_q  <= s2_q;
         end
      end
   end

endmodule // pin_sync

// ===== trig_src.sv
`timescale 1ns/10ps
// -------------------------------------------
// external trigger source
// -------------------------------------------
module trig_src (
   input wire logic ref_clk,
   output logic     start_pin,
   output logic     stop_pin,
   output logic     gate_pin
);
   // idle: start and stop low, gate pulled up
   initial begin
      start_pin = 1'h0;
      stop_pin = 1'h0;
      gate_pin = 1'h1;
   end
   // at least two cycles high, then low again before the next pulse
   task automatic pulse(input int w, input bit stp);
      if (stp) stop_pin = 1'h1;
      else start_pin = 1'h1;
      repeat (w < 2 ? 2 : w) @(negedge ref_clk);
      start_pin = 1'h0;
      stop_pin = 1'h0;
      repeat (w < 2 ? 2 : w) @(negedge ref_clk);
   endtask
   task automatic gate(input bit v);
      gate_pin = v;
   endtask
endmodule // trig_src
